// ---- verilog/hwc_config_top.sv ----
// Hardware configuration register with its pin-level control logic.
module hwc_config_top #(
    parameter int SUSPEND_DELAY = hwc_pkg::SUSPEND_DELAY_CYC   // Cycles from request to suspend.
) (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        reset,
    // Host command port.
    input  wire logic        cmd_strobe,
    input  wire logic [7:0]  cmd_code,
    input  wire logic        wr_strobe,
    input  wire logic [15:0] wr_data,
    input  wire logic        rd_strobe,
    output logic [15:0]      rd_data,
    output logic             rd_valid,
    // Mode register bits held elsewhere.
    input  wire logic        suspend_request,
    input  wire logic        soft_attach_enable,
    // Bus attach.
    output logic             pullup_enable,
    // Clocking.
    output logic             clock_output_pin,
    output logic             internal_clock_enable,
    // Suspend and wake-up.
    input  wire logic        resume_event,
    input  wire logic        chip_select_n,
    input  wire logic        vbus_present,
    output logic             suspended,
    output logic             power_switch,
    output logic             remote_wakeup,
    // DMA pins.
    input  wire logic        dma_request,
    output logic             dma_request_pin,
    input  wire logic        dma_ack_pin,
    output logic             dma_ack,
    output logic             ack_only_dma_mode,
    input  wire logic        end_of_transfer,
    output logic             end_of_transfer_pin,
    // Interrupt.
    input  wire logic        irq_request,
    output logic             irq_pin
);

    // *************************************************************************
    // Configuration register and host access
    // *************************************************************************
    logic [15:0]                 cfg_reg;        // The configuration word.
    hwc_pkg::hwc_access_type     access_reg;     // Access armed by the last command.
    logic [15:0]                 rd_data_reg;    // Word returned to the host.
    logic                        rd_valid_reg;   // Read answer marker.
    logic                        cmd_is_write;   // Command selects a write.
    logic                        cmd_is_read;    // Command selects a read.
    logic                        do_write;       // Data word is taken this cycle.
    logic                        do_read;        // Data word is read this cycle.

    // Command decode.
    assign cmd_is_write = cmd_code == hwc_pkg::CMD_WRITE_CFG;
    assign cmd_is_read  = cmd_code == hwc_pkg::CMD_READ_CFG;
    assign do_write     = wr_strobe && access_reg == hwc_pkg::ACC_WRITE;
    assign do_read      = rd_strobe && access_reg == hwc_pkg::ACC_READ;
    assign rd_data      = rd_data_reg;
    assign rd_valid     = rd_valid_reg;

    // The command arms exactly one data word; any other code disarms it, so a
    // stray data strobe never reaches this register.
    always_ff @(posedge mclk) begin
        if (reset) begin
            access_reg <= hwc_pkg::ACC_NONE;
        end else if (cmd_strobe) begin
            if (cmd_is_write) begin
                access_reg <= hwc_pkg::ACC_WRITE;
            end else if (cmd_is_read) begin
                access_reg <= hwc_pkg::ACC_READ;
            end else begin
                access_reg <= hwc_pkg::ACC_NONE;
            end
        end else if (do_write || do_read) begin
            access_reg <= hwc_pkg::ACC_NONE;
        end
    end

    // Only the hardware reset loads the defaults; there is deliberately no
    // USB bus reset input here, so a bus reset cannot disturb the fields.
    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_reg <= hwc_pkg::CFG_RESET;
        end else if (do_write) begin
            cfg_reg <= wr_data & hwc_pkg::CFG_WRITE_MASK;
        end
    end

    // Read answer, valid for one cycle after the data strobe.
    always_ff @(posedge mclk) begin
        if (reset) begin
            rd_data_reg  <= 16'h0000;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= do_read;
            if (do_read) begin
                rd_data_reg <= cfg_reg;
            end
        end
    end

    // *************************************************************************
    // Field decode
    // *************************************************************************
    wire       ext_pullup  = cfg_reg[hwc_pkg::BIT_EXT_PULLUP];      // External pull-up fitted.
    wire       slow_dis    = cfg_reg[hwc_pkg::BIT_SLOW_CLK_DIS];    // Slow clock disabled.
    wire       clocks_on   = cfg_reg[hwc_pkg::BIT_CLOCKS_ON];       // Clocks never gated.
    wire [3:0] clk_div     = cfg_reg[hwc_pkg::DIV_MSB:hwc_pkg::DIV_LSB];  // Clock output divider.
    wire       dreq_pol    = cfg_reg[hwc_pkg::BIT_DREQ_POL];        // DMA request polarity.
    wire       dack_pol    = cfg_reg[hwc_pkg::BIT_DACK_POL];        // DMA acknowledge polarity.
    wire       eot_pol     = cfg_reg[hwc_pkg::BIT_EOT_POL];         // End-of-transfer polarity.
    wire       wake_cs     = cfg_reg[hwc_pkg::BIT_WAKE_CS];         // Wake on chip select.
    wire       pwr_off     = cfg_reg[hwc_pkg::BIT_PWR_OFF];         // Power switch mode.
    wire       irq_mode    = cfg_reg[hwc_pkg::BIT_IRQ_MODE];        // Zero level, one pulse.
    wire       irq_pol     = cfg_reg[hwc_pkg::BIT_IRQ_POL];         // Interrupt polarity.

    // Applies a pin polarity: one means active high, zero active low.
    function automatic logic apply_pol(input logic level, input logic pol);
        apply_pol = pol ? level : ~level;
    endfunction

    // *************************************************************************
    // Bus attach
    // *************************************************************************
    // With an external resistor fitted the soft attach bit is simply ignored.
    assign pullup_enable = soft_attach_enable && !ext_pullup;

    // *************************************************************************
    // Suspend sequencing
    // *************************************************************************
    logic        susp_req_prev_reg;   // Request bit one cycle earlier.
    logic        susp_pending_reg;    // Delay counter is running.
    logic [31:0] susp_cnt_reg;        // Cycles waited since the request.
    logic        suspended_reg;       // Suspend state reached.
    logic        susp_start;          // One then zero seen on the request bit.
    logic        susp_done;           // Delay has run out.
    logic        wake_any;            // Any cause of leaving suspend.

    // The request is the falling edge that follows a written one.
    assign susp_start = susp_req_prev_reg && !suspend_request;
    assign susp_done  = susp_pending_reg && susp_cnt_reg >= 32'(SUSPEND_DELAY - 1);
    assign wake_any   = resume_event || remote_wakeup;
    assign suspended  = suspended_reg;

    // Delay from the request to the suspend state; a wake during the delay
    // cancels the pending suspend.
    always_ff @(posedge mclk) begin
        if (reset) begin
            susp_req_prev_reg <= 1'b0;
            susp_pending_reg  <= 1'b0;
            susp_cnt_reg      <= 32'h0000_0000;
            suspended_reg     <= 1'b0;
        end else begin
            susp_req_prev_reg <= suspend_request;
            if (wake_any) begin
                susp_pending_reg <= 1'b0;
                suspended_reg    <= 1'b0;
            end else if (susp_start) begin
                susp_pending_reg <= 1'b1;
                susp_cnt_reg     <= 32'h0000_0000;
            end else if (susp_done) begin
                susp_pending_reg <= 1'b0;
                suspended_reg    <= 1'b1;
            end else if (susp_pending_reg) begin
                susp_cnt_reg <= 32'(susp_cnt_reg + 32'h1);
            end
        end
    end

    // Clock gating follows the suspend state unless clocks are kept on.
    assign internal_clock_enable = clocks_on || !suspended_reg;

    // The suspend output becomes a high-active power switch when enabled.
    assign power_switch = pwr_off && suspended_reg;

    // A low chip select wakes the device only with bus power present.
    assign remote_wakeup = wake_cs && suspended_reg && !chip_select_n && vbus_present;

    // *************************************************************************
    // Clock output
    // *************************************************************************
    logic        fast_clk;        // Divided clock from the generator.
    logic        slow_clk_reg;    // Slow suspend clock level.
    logic [15:0] slow_cnt_reg;    // Cycles in the current slow half-period.

    hwc_clock_output_pin_gen u_clock_output_pin (
        .mclk    (mclk),
        .reset   (reset),
        .divider (clk_div),
        .clk_out (fast_clk)
    );

    // Slow suspend clock by counting system cycles per half-period.
    always_ff @(posedge mclk) begin
        if (reset) begin
            slow_cnt_reg <= 16'h0000;
            slow_clk_reg <= 1'b0;
        end else if (slow_cnt_reg == 16'(hwc_pkg::SLOW_HALF_CYC - 1)) begin
            slow_cnt_reg <= 16'h0000;
            slow_clk_reg <= ~slow_clk_reg;
        end else begin
            slow_cnt_reg <= 16'(slow_cnt_reg + 16'h1);
        end
    end

    // Clock output mux; registered so the switch itself cannot glitch. The
    // change of source at suspend may shorten one phase, a known limitation.
    logic clock_output_pin_reg;   // Registered clock output.
    always_ff @(posedge mclk) begin
        if (reset) begin
            clock_output_pin_reg <= 1'b0;
        end else if (!suspended_reg) begin
            clock_output_pin_reg <= fast_clk;
        end else if (!slow_dis) begin
            clock_output_pin_reg <= slow_clk_reg;
        end else begin
            clock_output_pin_reg <= 1'b0;
        end
    end
    assign clock_output_pin = clock_output_pin_reg;

    // *************************************************************************
    // DMA pins
    // *************************************************************************
    assign ack_only_dma_mode   = cfg_reg[hwc_pkg::BIT_ACK_ONLY];
    assign dma_request_pin     = apply_pol(dma_request, dreq_pol);
    assign dma_ack             = apply_pol(dma_ack_pin, dack_pol);
    assign end_of_transfer_pin = apply_pol(end_of_transfer, eot_pol);

    // *************************************************************************
    // Interrupt pin
    // *************************************************************************
    logic       irq_prev_reg;    // Request one cycle earlier.
    logic [7:0] pulse_cnt_reg;   // Cycles left in the current pulse.
    logic       irq_active;      // Pin asserted before polarity.

    // Each rising request starts one fixed-length pulse in pulsed mode.
    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_prev_reg  <= 1'b0;
            pulse_cnt_reg <= 8'h00;
        end else begin
            irq_prev_reg <= irq_request;
            if (irq_request && !irq_prev_reg) begin
                pulse_cnt_reg <= 8'(hwc_pkg::IRQ_PULSE_CYC);
            end else if (pulse_cnt_reg != 8'h00) begin
                pulse_cnt_reg <= 8'(pulse_cnt_reg - 8'h1);
            end
        end
    end

    assign irq_active = irq_mode ? (pulse_cnt_reg != 8'h00) : irq_request;
    assign irq_pin    = apply_pol(irq_active, irq_pol);

endmodule

// ---- verilog/hwc_pkg.sv ----
// Constants shared by the hardware configuration register block.
// *****************************************************************************
// *****************************************************************************
package hwc_pkg;

    // *************************************************************************
    // Register layout
    // *************************************************************************
    localparam int          CFG_WIDTH         = 16;          // Register width in bits.
    localparam logic [15:0] CFG_RESET         = 16'h2340;    // Value after hardware reset.
    localparam logic [15:0] CFG_WRITE_MASK    = 16'h7fff;    // Bit 15 is reserved and reads zero.
    localparam int          BIT_EXT_PULLUP    = 14;          // External pull-up select.
    localparam int          BIT_SLOW_CLK_DIS  = 13;          // Slow suspend clock disable.
    localparam int          BIT_CLOCKS_ON     = 12;          // Clocks always on.
    localparam int          DIV_MSB           = 11;          // Clock output divider, top bit.
    localparam int          DIV_LSB           = 8;           // Clock output divider, bottom bit.
    localparam int          BIT_ACK_ONLY      = 7;           // Acknowledge-only DMA mode.
    localparam int          BIT_DREQ_POL      = 6;           // DMA request polarity.
    localparam int          BIT_DACK_POL      = 5;           // DMA acknowledge polarity.
    localparam int          BIT_EOT_POL       = 4;           // End-of-transfer polarity.
    localparam int          BIT_WAKE_CS       = 3;           // Wake on chip select.
    localparam int          BIT_PWR_OFF       = 2;           // Suspend power-off.
    localparam int          BIT_IRQ_MODE      = 1;           // Interrupt signalling mode.
    localparam int          BIT_IRQ_POL       = 0;           // Interrupt polarity.

    // *************************************************************************
    // Command codes on the host port
    // *************************************************************************
    localparam logic [7:0]  CMD_WRITE_CFG     = 8'hba;       // Write one word to the register.
    localparam logic [7:0]  CMD_READ_CFG      = 8'hbb;       // Read one word from the register.

    // *************************************************************************
    // Timing
    // *************************************************************************
    localparam int          MCLK_MHZ          = 125;         // System clock rate.
    localparam int          MCLK_PERIOD_NS    = 8;           // System clock period.
    localparam int          SUSPEND_DELAY_MS  = 2;           // Delay from request to suspend.
    localparam int          SUSPEND_DELAY_CYC = SUSPEND_DELAY_MS * 1000 * MCLK_MHZ * 1000 / 1000;
    localparam int          IRQ_PULSE_NS      = 166;         // Pulse length in pulsed mode.
    localparam int          IRQ_PULSE_CYC     = (IRQ_PULSE_NS / MCLK_PERIOD_NS) < 1 ? 1
                                              : IRQ_PULSE_NS / MCLK_PERIOD_NS;
    localparam int          SLOW_CLK_KHZ      = 100;         // Slow suspend clock rate.
    localparam int          SLOW_HALF_CYC     = MCLK_MHZ * 1000 / (2 * SLOW_CLK_KHZ);
    localparam int          PLL_MHZ           = 48;          // Reference for the clock output.
    localparam logic [7:0]  TICK_STEP         = 8'(2 * PLL_MHZ);  // Half-phase ticks per microsecond.
    localparam logic [7:0]  TICK_MOD          = 8'(MCLK_MHZ);

    // Host port access that the last command selected.
    typedef enum logic [1:0] {
        ACC_NONE,
        ACC_WRITE,
        ACC_READ
    } hwc_access_type;

endpackage

// ---- verilog/hwc_clock_output_pin_gen.sv ----
// Glitch-free programmable clock output generator.
module hwc_clock_output_pin_gen (
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       reset,
    // Control.
    input  wire logic [3:0] divider,
    // Output.
    output logic            clk_out
);

    // *************************************************************************
    // Half-phase tick at twice the 48 MHz reference
    // *************************************************************************
    // Phase accumulator; ticks average 96 per 125 clocks, so the output
    // frequency is exact on average with one clock of edge jitter.
    logic [7:0] acc_reg;     // Phase accumulator.
    logic [7:0] acc_next;    // Next accumulator value.
    logic [8:0] acc_sum;     // Unreduced sum.
    logic       tick;        // One-cycle half-phase tick.

    assign acc_sum  = {1'b0, acc_reg} + {1'b0, hwc_pkg::TICK_STEP};
    assign tick     = acc_sum >= {1'b0, hwc_pkg::TICK_MOD};
    assign acc_next = tick ? 8'(acc_sum - {1'b0, hwc_pkg::TICK_MOD}) : acc_sum[7:0];

    // Accumulator update.
    always_ff @(posedge mclk) begin
        if (reset) begin
            acc_reg <= 8'h00;
        end else begin
            acc_reg <= acc_next;
        end
    end

    // *************************************************************************
    // Divider with boundary-only reload
    // *************************************************************************
    logic [3:0] active_div_reg;  // Divider in use for the current period.
    logic [3:0] phase_cnt_reg;   // Ticks counted in the current phase.
    logic       out_reg;         // Output level.
    logic       phase_end;       // Current phase completes on this tick.
    logic       period_end;      // Low phase ends, so the period ends.

    assign phase_end  = tick && (phase_cnt_reg == active_div_reg);
    assign period_end = phase_end && out_reg == 1'b0;
    assign clk_out    = out_reg;

    // Each phase lasts divider plus one ticks, so one period is 48/(N+1) MHz.
    // The divider is only sampled at the end of a low phase, so neither phase
    // can be cut short when software rewrites it.
    always_ff @(posedge mclk) begin
        if (reset) begin
            active_div_reg <= hwc_pkg::CFG_RESET[hwc_pkg::DIV_MSB:hwc_pkg::DIV_LSB];
            phase_cnt_reg  <= 4'h0;
            out_reg        <= 1'b0;
        end else if (phase_end) begin
            phase_cnt_reg <= 4'h0;
            out_reg       <= ~out_reg;
            if (period_end) begin
                active_div_reg <= divider;
            end
        end else if (tick) begin
            phase_cnt_reg <= 4'(phase_cnt_reg + 4'h1);
        end
    end

endmodule

// ---- test/hwc_config_properties.sv ----
// Port assertions for the hardware configuration register block.
module hwc_config_props #(
    parameter int SUSPEND_DELAY = 50  // Cycles from suspend request to suspend.
) (
    // Clock, reset and host port.
    input wire logic        mclk, reset, cmd_strobe, wr_strobe, rd_strobe, rd_valid,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] wr_data, rd_data,
    // Pins and status.
    input wire logic        suspend_request, soft_attach_enable, pullup_enable, clock_output_pin, suspended,
    input wire logic        internal_clock_enable, chip_select_n, vbus_present, power_switch, remote_wakeup,
    input wire logic        dma_request, dma_request_pin, dma_ack_pin, dma_ack, ack_only_dma_mode,
    input wire logic        end_of_transfer, end_of_transfer_pin, irq_request, irq_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LO = SUSPEND_DELAY - 1;  // Earliest suspend entry.
    localparam int HI = SUSPEND_DELAY + 2;  // Latest suspend entry, with sampling slack.
    logic [15:0] cfg_reg;  // Shadow of the stored word, so pins can be tied to it.
    logic [1:0]  arm_reg;  // Armed access: 1 write, 2 read.
    // Shadow follows the host port; a data strobe always uses up the arming.
    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_reg <= hwc_pkg::CFG_RESET;
            arm_reg <= 2'h0;
        end else begin
            if (cmd_strobe)
                arm_reg <= {cmd_code == hwc_pkg::CMD_READ_CFG, cmd_code == hwc_pkg::CMD_WRITE_CFG};
            else if (wr_strobe | rd_strobe)
                arm_reg <= 2'h0;
            if (wr_strobe && !cmd_strobe && arm_reg == 2'h1)
                cfg_reg <= wr_data & hwc_pkg::CFG_WRITE_MASK;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    attach_gate_a: assert property (pullup_enable == (soft_attach_enable & ~cfg_reg[14]))
        else $error("pull-up enable wrong");
    dma_pol_a: assert property ({dma_request_pin, dma_ack, end_of_transfer_pin} ==
        {dma_request ^ ~cfg_reg[6], dma_ack_pin ^ ~cfg_reg[5], end_of_transfer ^ ~cfg_reg[4]})
        else $error("dma pin polarity wrong");
    dma_mode_a: assert property (ack_only_dma_mode == cfg_reg[7]) else $error("dma mode wrong");
    clock_gate_a: assert property (internal_clock_enable == (cfg_reg[12] | ~suspended))
        else $error("clock gating wrong");
    power_wake_a: assert property ({power_switch, remote_wakeup} ==
        {cfg_reg[2] & suspended, cfg_reg[3] & suspended & ~chip_select_n & vbus_present})
        else $error("power switch or wake wrong");
    read_word_a: assert property (rd_strobe && !cmd_strobe && arm_reg == 2'h2
        |=> rd_valid && rd_data == $past(cfg_reg)) else $error("read answer wrong");
    irq_level_a: assert property (!cfg_reg[1] |-> irq_pin == (irq_request ^ ~cfg_reg[0]))
        else $error("level interrupt wrong");
    irq_pulse_a: assert property (cfg_reg[1] && $rose(irq_request) |=> (irq_pin == cfg_reg[0]) [*8])
        else $error("interrupt pulse short");
    suspend_delay_a: assert property ($fell(suspend_request) |-> ##[LO:HI] suspended)
        else $error("suspend entry late");
    lazy_off_a: assert property (cfg_reg[13] && suspended && $past(suspended) |-> !clock_output_pin)
        else $error("slow clock not parked");
    cover property ($rose(suspended));
    cover property (rd_valid);
    cover property (cfg_reg[1] && $rose(irq_request));
endmodule

// ---- test/hwc_dma_partner.sv ----
// Behavioural model of the system DMA controller on the far side.
module hwc_dma_partner (
    // Clock and bench settings.
    input  wire logic       mclk,
    input  wire logic       req_high,
    input  wire logic       ack_high,
    input  wire logic [3:0] lag,
    // Handshake pins.
    input  wire logic       req_pin,
    output logic            ack_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_reg;                          // Cycles the request has been held.
    wire        req_seen = (req_pin == req_high);
    // Acknowledge only a held request; lag lets the bench try a slow controller.
    always_ff @(posedge mclk) begin
        wait_reg <= !req_seen ? 4'h0 : (wait_reg == lag) ? wait_reg : wait_reg + 4'h1;
        ack_pin  <= (req_seen && wait_reg == lag) ? ack_high : ~ack_high;
    end
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the hardware configuration register block.
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SD = 50;  // Short suspend delay keeps the run brief.
    logic mclk = 1'b0, reset = 1'b1, cmd_strobe = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0, suspend_request = 1'b0;
    logic soft_attach_enable = 1'b1, resume_event = 1'b0, chip_select_n = 1'b1, vbus_present = 1'b1;
    logic dma_request = 1'b0, end_of_transfer = 1'b0, irq_request = 1'b0, req_high = 1'b1, ack_high = 1'b0;
    logic [3:0]  lag = 4'h0;
    logic [7:0]  cmd_code = 8'h00;
    logic [15:0] wr_data = 16'h0000, rd_data;
    logic rd_valid, pullup_enable, clock_output_pin, internal_clock_enable, suspended, power_switch;
    logic remote_wakeup, dma_request_pin, dma_ack_pin, dma_ack, ack_only_dma_mode, end_of_transfer_pin, irq_pin;
    int   checks = 0, mismatches = 0, cycles = 0;
    hwc_config_top #(.SUSPEND_DELAY(SD)) DUT (.*);
    hwc_dma_partner partner (.mclk, .req_high, .ack_high, .lag, .req_pin(dma_request_pin), .ack_pin(dma_ack_pin));
    initial begin
        forever #4 mclk = ~mclk;
    end
    // Cut a hang short; the tests need about 19000 cycles.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            results();
        end
    end
    // Inputs always change 1 ns after the rising edge.
    task automatic cyc(input int n = 1);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // One-word access: command, then data strobe; a read is checked against d.
    task automatic acc(input logic rd, input logic [15:0] d);
        cmd_strobe = 1'b1;
        cmd_code   = rd ? hwc_pkg::CMD_READ_CFG : hwc_pkg::CMD_WRITE_CFG;
        cyc();
        cmd_strobe = 1'b0;
        rd_strobe  = rd;
        wr_strobe  = !rd;
        wr_data    = d;
        cyc();
        {rd_strobe, wr_strobe} = 2'b00;
        if (rd) `CHK("rd_data", {1'b1, d}, {rd_valid, rd_data})
    endtask
    task automatic results();
        $display("Checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        int e, n, lo, ph, mn;
        logic [15:0] v;
        logic pv;
        cyc(4);
        reset = 1'b0;
        acc(1'b1, 16'h2340);
        {wr_strobe, wr_data} = {1'b1, 16'hffff};
        cyc();
        wr_strobe = 1'b0;
        acc(1'b1, 16'h2340);
        acc(1'b0, 16'hffff);
        acc(1'b1, 16'h7fff);
        `CHK("pullup", 1'b0, pullup_enable)
        $display("Access test done");
        // Descending divider steps: the first phase after a change must not be a runt.
        acc(1'b0, 16'h2f00);
        cyc(60);
        for (int d = 15; d >= 0; d--) begin
            acc(1'b0, 16'h2000 | 16'(d << 8));
            e = 0;
            ph = -5000;
            mn = 999;
            repeat (1000) begin
                pv = clock_output_pin;
                cyc();
                ph++;
                if (clock_output_pin !== pv) begin
                    if (ph > 0 && ph < mn) mn = ph;
                    ph = 0;
                    e += int'(clock_output_pin);
                end
            end
            lo = 384 / (d + 1);
            `CHK("clk_rate_ok", 1'b1, e >= lo - 3 && e <= lo + 2)
            `CHK("clk_phase_ok", 1'b1, mn >= (d + 1) * 125 / 96 - 1)
        end
        `CHK("pullup", 1'b1, pullup_enable)
        $display("Clock output test done");
        for (int p = 0; p < 16; p++) begin
            v = 16'h2300 | 16'(p << 4);
            acc(1'b0, v);
            {req_high, ack_high, lag} = {v[6], v[5], 4'(p)};
            cyc();
            `CHK("dma_idle", 1'b0, dma_ack)
            {dma_request, end_of_transfer} = 2'b11;
            for (n = 0; n < 30 && dma_ack !== 1'b1; n++) cyc();
            `CHK("dma_ack", 1'b1, dma_ack)
            `CHK("dma_wait", p + 1, n)
            `CHK("eot_pin", v[4], end_of_transfer_pin)
            `CHK("ack_only", v[7], ack_only_dma_mode)
            {dma_request, end_of_transfer} = 2'b00;
            cyc(3);
        end
        $display("DMA test done");
        for (int m = 0; m < 4; m++) begin
            v = 16'h2300 | 16'(m);
            acc(1'b0, v);
            cyc(2);
            `CHK("irq_idle", ~v[0], irq_pin)
            irq_request = 1'b1;
            n = 0;
            repeat (40) begin
                cyc();
                n += int'(irq_pin === v[0]);
            end
            `CHK("irq_active", v[1] ? hwc_pkg::IRQ_PULSE_CYC : 40, n)
            irq_request = 1'b0;
        end
        $display("Interrupt test done");
        // Second pass keeps clocks on and power-off clear to reach the other branches.
        for (int s = 0; s < 2; s++) begin
            v = s ? 16'h1300 : 16'h230c;
            acc(1'b0, v);
            suspend_request = 1'b1;
            cyc(2);
            suspend_request = 1'b0;
            for (n = 0; n < 2 * SD && suspended !== 1'b1; n++) cyc();
            `CHK("suspend_delay_ok", 1'b1, n >= SD - 1 && n <= SD + 3)
            cyc(4);
            `CHK("clk_enable", v[12], internal_clock_enable)
            `CHK("power_switch", v[2], power_switch)
            e = 0;
            repeat (1300) begin
                pv = clock_output_pin;
                cyc();
                e += int'(clock_output_pin !== pv);
            end
            `CHK("slow_clock_ok", 1'b1, v[13] ? e == 0 : e >= 2 && e <= 3)
            {chip_select_n, vbus_present} = 2'b00;
            cyc(2);
            `CHK("no_wake_unpowered", 1'b1, suspended)
            vbus_present = 1'b1;
            cyc(2);
            `CHK("wake_on_cs", ~v[3], suspended)
            {chip_select_n, resume_event} = 2'b11;
            cyc();
            resume_event = 1'b0;
            cyc(2);
        end
        $display("Suspend test done");
        results();
    end
endmodule
bind hwc_config_top hwc_config_props #(.SUSPEND_DELAY(SUSPEND_DELAY)) props (.*);
